// ---- verilog/bcs_pkg.sv ----
// Package for the commutation sequencer: map, codes, timing
package bcs_pkg;
    // Register byte offsets
    localparam logic [7:0] BCS_CTRL_OFS = 8'h00;
    localparam logic [7:0] BCS_STAT_OFS = 8'h04;
    localparam logic [7:0] BCS_TRIP_OFS = 8'h08;
    localparam logic [7:0] BCS_COMM_OFS = 8'h0C;
    // Control field layout and reset value (parked in reset)
    localparam int BCS_CTRL_W = 4;
    localparam logic [3:0] BCS_CTRL_RST = 4'h8;
    // Drive codes per phase pair {hi,lo}: Z=00 L=01 H=10
    localparam logic [5:0] BCS_DRV_S0 = 6'h06;
    localparam logic [5:0] BCS_DRV_S1 = 6'h24;
    localparam logic [5:0] BCS_DRV_S2 = 6'h21;
    localparam logic [5:0] BCS_DRV_S3 = 6'h09;
    localparam logic [5:0] BCS_DRV_S4 = 6'h18;
    localparam logic [5:0] BCS_DRV_S5 = 6'h12;
    localparam logic [5:0] BCS_DRV_BRAKE = 6'h15;
    localparam logic [5:0] BCS_DRV_TEST = 6'h00;
    // Start oscillator period
    localparam int BCS_CLK_MHZ = 100;
    localparam int BCS_START_MS = 500;
    localparam int BCS_START_CYC = BCS_START_MS * 1000 * BCS_CLK_MHZ;

    typedef struct packed {
        logic hi;
        logic lo;
    } bcs_phase_t;

    typedef struct packed {
        logic park;
        logic test;
        logic brake;
        logic dir;
    } bcs_ctrl_t;

    typedef enum logic [1:0] {
        BCS_NORMAL,
        BCS_PARK,
        BCS_TEST,
        BCS_BRAKE
    } bcs_mode_t;

    typedef enum logic [2:0] {
        BCS_ST0,
        BCS_ST1,
        BCS_ST2,
        BCS_ST3,
        BCS_ST4,
        BCS_ST5
    } bcs_step_t;
endpackage : bcs_pkg

// ---- verilog/bcs_sync.sv ----
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module bcs_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Data
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= d_in;
            sync_r <= meta_r;
        end
    end

    assign q_out = sync_r;
endmodule : bcs_sync

// ---- verilog/bcs_sequencer.sv ----
// Six-step commutation sequencer with Wishbone registers
`timescale 1ns/100ps
module bcs_sequencer
    import bcs_pkg::*;
#(
    parameter int START_CYCLES = BCS_START_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // Motor side pins
    input wire logic zero_cross_in,
    input wire logic [5:0] therm_hot_in,
    output bcs_phase_t phase_a_out,
    output bcs_phase_t phase_b_out,
    output bcs_phase_t phase_c_out
);
    logic [6:0] pins_s;
    logic zc_s;
    logic [5:0] hot_s;
    logic zc_d_r;
    bcs_ctrl_t ctrl_r;
    bcs_step_t step_r;
    bcs_step_t step_nxt;
    logic [5:0] drive_r;
    logic [5:0] drive_nxt;
    logic [5:0] want;
    logic [5:0] trip_r;
    logic [31:0] cnt_r;
    logic [31:0] comm_cnt_r;
    logic [31:0] rdata;
    logic ack_r;
    logic [31:0] rdat_r;
    bcs_mode_t mode;
    logic req;
    logic wr_ctrl;
    logic wr_trip;
    logic zc_rise;
    logic start_pulse;
    logic comm;

    // Pin synchronisation
    bcs_sync #(.W(7)) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in({zero_cross_in, therm_hot_in}),
        .q_out(pins_s)
    );
    assign zc_s = pins_s[6];
    assign hot_s = pins_s[5:0];

    // Mode priority
    assign mode = ctrl_r.brake ? BCS_BRAKE :
                  ctrl_r.test ? BCS_TEST :
                  ctrl_r.park ? BCS_PARK : BCS_NORMAL;

    // Commutation sources
    assign zc_rise = zc_s & ~zc_d_r;
    assign start_pulse = (mode == BCS_NORMAL) &&
                         (cnt_r == 32'(START_CYCLES - 1));
    assign comm = (mode == BCS_NORMAL) && (zc_rise || start_pulse);

    // Step sequencing
    always_comb
    begin
        step_nxt = step_r;
        if (mode == BCS_PARK)
        begin
            step_nxt = ctrl_r.dir ? BCS_ST0 : BCS_ST1;
        end
        else if (comm)
        begin
            case (step_r)
                BCS_ST0: step_nxt = ctrl_r.dir ? BCS_ST1 : BCS_ST5;
                BCS_ST1: step_nxt = ctrl_r.dir ? BCS_ST2 : BCS_ST0;
                BCS_ST2: step_nxt = ctrl_r.dir ? BCS_ST3 : BCS_ST1;
                BCS_ST3: step_nxt = ctrl_r.dir ? BCS_ST4 : BCS_ST2;
                BCS_ST4: step_nxt = ctrl_r.dir ? BCS_ST5 : BCS_ST3;
                BCS_ST5: step_nxt = ctrl_r.dir ? BCS_ST0 : BCS_ST4;
                default: step_nxt = BCS_ST0;
            endcase
        end
    end

    // Demanded transistors
    always_comb
    begin
        case (step_nxt)
            BCS_ST0: want = BCS_DRV_S0;
            BCS_ST1: want = BCS_DRV_S1;
            BCS_ST2: want = BCS_DRV_S2;
            BCS_ST3: want = BCS_DRV_S3;
            BCS_ST4: want = BCS_DRV_S4;
            BCS_ST5: want = BCS_DRV_S5;
            default: want = BCS_DRV_TEST;
        endcase
        if (mode == BCS_BRAKE)
        begin
            want = BCS_DRV_BRAKE;
        end
        else if (mode == BCS_TEST)
        begin
            want = BCS_DRV_TEST;
        end
    end
    assign drive_nxt = want & ~hot_s;

    // Bus decode
    assign req = wb_cyc_in & wb_stb_in & ~ack_r;
    assign wr_ctrl = req & wb_we_in & wb_sel_in[0] &
                     (wb_adr_in == BCS_CTRL_OFS);
    assign wr_trip = req & wb_we_in & wb_sel_in[0] &
                     (wb_adr_in == BCS_TRIP_OFS);
    assign rdata = (wb_adr_in == BCS_CTRL_OFS) ? {28'h0000000, ctrl_r} :
                   (wb_adr_in == BCS_STAT_OFS) ?
                       {20'h00000, mode, drive_r, 1'b0, step_r} :
                   (wb_adr_in == BCS_TRIP_OFS) ? {26'h0, trip_r} :
                   (wb_adr_in == BCS_COMM_OFS) ? comm_cnt_r : 32'h00000000;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ack_r <= 1'b0;
            rdat_r <= 32'h00000000;
            ctrl_r <= BCS_CTRL_RST;
        end
        else
        begin
            ack_r <= req;
            rdat_r <= req ? rdata : 32'h00000000;
            if (wr_ctrl)
                ctrl_r <= wb_dat_in[BCS_CTRL_W-1:0];
        end
    end

    // Sequencer state
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            zc_d_r <= 1'b0;
            // Park step for the reset direction
            step_r <= BCS_ST1;
            drive_r <= BCS_DRV_TEST;
            cnt_r <= 32'h00000000;
            comm_cnt_r <= 32'h00000000;
            trip_r <= 6'h00;
        end
        else
        begin
            zc_d_r <= zc_s;
            step_r <= step_nxt;
            drive_r <= drive_nxt;
            if (comm || mode != BCS_NORMAL)
                cnt_r <= 32'h00000000;
            else
                cnt_r <= cnt_r + 32'h00000001;
            if (comm)
                comm_cnt_r <= comm_cnt_r + 32'h00000001;
            // Set wins over write-one-to-clear
            trip_r <= (trip_r & ~(wr_trip ? wb_dat_in[5:0] : 6'h00)) |
                      (want & hot_s);
        end
    end

    assign wb_ack_out = ack_r;
    assign wb_dat_out = rdat_r;
    assign phase_a_out = drive_r[5:4];
    assign phase_b_out = drive_r[3:2];
    assign phase_c_out = drive_r[1:0];

    // Checks
    property p_brake;
        @(posedge clk_in) disable iff (rst_in)
        ctrl_r.brake |=> drive_r == (BCS_DRV_BRAKE & ~$past(hot_s));
    endproperty
    a_brake: assert property (p_brake)
        else $error("brake did not pull all phases low");

    property p_prio;
        @(posedge clk_in) disable iff (rst_in)
        ctrl_r.brake || ctrl_r.test || ctrl_r.park |=>
            comm_cnt_r == $past(comm_cnt_r);
    endproperty
    a_prio: assert property (p_prio)
        else $error("commutation outside normal mode");

    property p_test;
        @(posedge clk_in) disable iff (rst_in)
        ctrl_r.test && !ctrl_r.brake |=> drive_r == BCS_DRV_TEST;
    endproperty
    a_test: assert property (p_test)
        else $error("test mode left a transistor on");

    property p_park;
        @(posedge clk_in) disable iff (rst_in)
        mode == BCS_PARK |=>
            step_r == ($past(ctrl_r.dir) ? BCS_ST0 : BCS_ST1);
    endproperty
    a_park: assert property (p_park)
        else $error("park state wrong for direction");

    property p_fwd;
        @(posedge clk_in) disable iff (rst_in)
        comm && ctrl_r.dir && step_r != BCS_ST5 |=>
            step_r == bcs_step_t'($past(step_r) + 3'h1);
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("forward step did not advance by one");

    property p_rev;
        @(posedge clk_in) disable iff (rst_in)
        comm && !ctrl_r.dir && step_r != BCS_ST0 |=>
            step_r == bcs_step_t'($past(step_r) - 3'h1);
    endproperty
    a_rev: assert property (p_rev)
        else $error("reverse step did not go back by one");

    property p_wrap;
        @(posedge clk_in) disable iff (rst_in)
        comm && ctrl_r.dir && step_r == BCS_ST5 |=> step_r == BCS_ST0;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("sequence did not wrap");

    property p_hot;
        @(posedge clk_in) disable iff (rst_in)
        (want & hot_s) != 6'h00 |=>
            (drive_r & $past(hot_s)) == 6'h00 && trip_r != 6'h00;
    endproperty
    a_hot: assert property (p_hot)
        else $error("hot transistor stayed on");

    property p_cold_off;
        @(posedge clk_in) disable iff (rst_in)
        !wr_trip && trip_r == 6'h00 && (want & hot_s) == 6'h00 |=>
            trip_r == 6'h00;
    endproperty
    a_cold_off: assert property (p_cold_off)
        else $error("sensor of an off transistor was counted");

    property p_osc;
        @(posedge clk_in) disable iff (rst_in)
        comm |=> cnt_r == 32'h00000000 && comm_cnt_r == $past(comm_cnt_r) + 1;
    endproperty
    a_osc: assert property (p_osc)
        else $error("start oscillator not restarted");

    property p_start;
        @(posedge clk_in) disable iff (rst_in)
        start_pulse |=> step_r != $past(step_r);
    endproperty
    a_start: assert property (p_start)
        else $error("start pulse did not advance");
endmodule : bcs_sequencer

// ---- sim/bcs_motor_model.sv ----
// Motor winding model: zero-cross source, sensors, short watch
`timescale 1ns/100ps
module bcs_motor_model
    import bcs_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Bench requests
    input wire logic cross_req_in,
    input wire logic [5:0] hot_mask_in,
    // Sequencer drive
    input wire bcs_phase_t phase_a_in,
    input wire bcs_phase_t phase_b_in,
    input wire bcs_phase_t phase_c_in,
    // Back to sequencer and bench
    output logic zero_cross_out,
    output logic [5:0] therm_hot_out,
    output logic short_out
);
    logic [1:0] hold_r = 2'h0;

    // Zero-cross pulse three cycles wide
    always_ff @(posedge clk_in)
        if (cross_req_in)
            hold_r <= 2'h3;
        else if (hold_r != 2'h0)
            hold_r <= hold_r - 2'h1;
    assign zero_cross_out = (hold_r != 2'h0);
    // Sensor per transistor
    assign therm_hot_out = hot_mask_in;
    // Both transistors of a phase on
    assign short_out = &phase_a_in | &phase_b_in | &phase_c_in;
endmodule : bcs_motor_model

// ---- sim/tb_top.sv ----
// Bench for the commutation sequencer
`timescale 1ns/100ps
module tb_top;
    import bcs_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic req = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [5:0] hot = 6'h00;
    logic [5:0] hot_w;
    logic ack, zc, short_w;
    bcs_phase_t pa, pb, pc;
    wire [5:0] drv = {pa, pb, pc};
    logic [5:0] tbl [6] = '{BCS_DRV_S0, BCS_DRV_S1, BCS_DRV_S2,
        BCS_DRV_S3, BCS_DRV_S4, BCS_DRV_S5};
    int failures = 0;
    int tests_run = 0;

    always #5 clk_in = ~clk_in;

    bcs_sequencer #(.START_CYCLES(40)) bcs_sequencer_inst (
        .clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .zero_cross_in(zc), .therm_hot_in(hot_w),
        .phase_a_out(pa), .phase_b_out(pb), .phase_c_out(pc));

    bcs_motor_model bcs_motor_model_inst (
        .clk_in(clk_in), .cross_req_in(req), .hot_mask_in(hot),
        .phase_a_in(pa), .phase_b_in(pb), .phase_c_in(pc),
        .zero_cross_out(zc), .therm_hot_out(hot_w),
        .short_out(short_w));

    task automatic tally_and_finish;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] s, e);
        tests_run++;
        if (s !== e)
        begin
            failures++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask : chk

    // Classic single cycle, waits for ack
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1)
        begin
            failures++;
            tally_and_finish();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_in);
    endtask : wait_n

    task automatic pulse;
        @(posedge clk_in);
        req <= 1'b1;
        @(posedge clk_in);
        req <= 1'b0;
        wait_n(8);
    endtask : pulse

    // Park, then seven commutations in one direction
    task automatic run(input logic d, inout int k);
        logic [31:0] q;
        wb(1'b1, BCS_CTRL_OFS, {28'h0, 3'h4, d}, q);
        wait_n(3);
        k = d ? 0 : 1;
        chk("park", 32'(drv), 32'(tbl[k]));
        wb(1'b1, BCS_CTRL_OFS, {28'h0, 3'h0, d}, q);
        repeat (7)
        begin
            pulse();
            k = d ? (k + 1) % 6 : (k + 5) % 6;
            chk("step", 32'(drv), 32'(tbl[k]));
            chk("short", 32'(short_w), 32'h0);
        end
    endtask : run

    initial
    begin
        logic [31:0] q;
        int k;
        int n;
        wait_n(8);
        rst_in <= 1'b0;
        wait_n(2);
        chk("reset park", 32'(drv), 32'(BCS_DRV_S1));
        wb(1'b0, BCS_CTRL_OFS, 32'h0, q);
        chk("ctrl rst", q, 32'(BCS_CTRL_RST));
        wb(1'b1, 8'h10, 32'hF, q);
        wb(1'b0, 8'h10, 32'h0, q);
        chk("unmapped", q, 32'h0);
        for (k = 1; k < 8; k++)
        begin
            wb(1'b1, BCS_CTRL_OFS, 32'({k[2:0], 1'b1}), q);
            wait_n(3);
            chk("prio drv", 32'(drv), 32'(k[0] ? BCS_DRV_BRAKE :
                k[1] ? BCS_DRV_TEST : BCS_DRV_S0));
            wb(1'b0, BCS_STAT_OFS, 32'h0, q);
            chk("prio mode", 32'(q[11:10]),
                32'(k[0] ? 2'h3 : k[1] ? 2'h2 : 2'h1));
        end
        run(1'b1, k);
        run(1'b0, k);
        wait_n(20);
        chk("osc quiet", 32'(drv), 32'(tbl[k]));
        n = 0;
        while (drv === tbl[k] && n < 60)
        begin
            @(posedge clk_in);
            n++;
        end
        if (n == 60)
        begin
            failures++;
            tally_and_finish();
        end
        chk("osc step", 32'(drv), 32'(tbl[5]));
        wb(1'b1, BCS_CTRL_OFS, 32'h9, q);
        wb(1'b0, BCS_COMM_OFS, 32'h0, q);
        chk("comm count", q, 32'h0000000F);
        wait_n(3);
        hot <= 6'h04;
        wait_n(5);
        chk("hot on", 32'(drv), 32'h02);
        wb(1'b1, BCS_TRIP_OFS, 32'h3F, q);
        wb(1'b0, BCS_TRIP_OFS, 32'h0, q);
        chk("trip set wins", q, 32'h04);
        hot <= 6'h39;
        wait_n(5);
        chk("hot off", 32'(drv), 32'(BCS_DRV_S0));
        wb(1'b0, BCS_TRIP_OFS, 32'h0, q);
        chk("trip kept", q, 32'h04);
        wb(1'b1, BCS_TRIP_OFS, 32'h3F, q);
        wb(1'b0, BCS_TRIP_OFS, 32'h0, q);
        chk("trip cleared", q, 32'h00);
        hot <= 6'h00;
        tally_and_finish();
    end
endmodule : tb_top
